// *** hdl/tsc_space_regs.svh ***
/*
 Constants of the tape space command block: command byte fields, sense keys, timing.
 Assumes inclusion by bare name from the package and the property checks file.
*/
`ifndef TSC_SPACE_REGS_SVH
`define TSC_SPACE_REGS_SVH
// What this block does
// RQ1: decode space type in byte 1 bits 2..0: blocks, filemarks, end of data.
// RQ2: count in bytes 2..4; positive moves forward, ends past last item.
// RQ3: negative count moves backward by magnitude, ends on start side.
// RQ4: zero count leaves position unchanged and completes with good status.
// RQ5: end-of-data type ignores count, searches forward, positions for append.
// RQ6: reverse space after write first flushes buffer and end mark, up to 12 s.
// RQ7: flush failure gives check condition, space skipped; initiator asks sense.
// RQ8: forward space directly after write is illegal request 5h.
// RQ9: end-of-data space on legacy format tape is illegal request.
// RQ10: byte 5 bit 7 set stops at first end mark; clear passes early one.
// RQ11: that flag is ignored on units without directory support.
// RQ12: directory units skip early end mark fast over up to 20 MBytes.
// RQ13: filemark during block space stops past it, no sense 0h, filemark, residue.
// RQ14: backward media error residue may be negative two's complement.
// RQ15: blank tape during block or filemark space gives blank check, residue.
// RQ16: crossing first end mark silent; second end mark gives blank check 8h.
// RQ17: physical end gives medium error 3h, end-of-medium, physical end, residue.
// RQ18: physical start gives no sense, end-of-medium, logical start, negative residue.
// RQ19: unrecoverable error aborts with key 3h or 4h; residue excludes bad block.
// RQ20: with disconnection enabled the device may release the bus meanwhile.
// RQ21: fixed or variable block spacing follows the recorded block kind.
// RQ22: other space types are illegal request without tape motion.
`define TSC_CODE_LSB 0
`define TSC_CODE_MSB 2
`define TSC_STOPFIRST_BIT 7
`define TSC_TYPE_BLOCKS 3'h0
`define TSC_TYPE_FMARKS 3'h1
`define TSC_TYPE_EOD 3'h3
`define TSC_KEY_NOSENSE 4'h0
`define TSC_KEY_MEDIUM 4'h3
`define TSC_KEY_HARDWARE 4'h4
`define TSC_KEY_ILLEGAL 4'h5
`define TSC_KEY_BLANK 4'h8
`define TSC_FLUSH_MAX_S 12
`define TSC_CLK_HZ 200000000
`define TSC_ERASE_MBYTES 20
`endif

// *** hdl/tsc_space_pkg.sv ***
/*
 Types of the tape space command block.
 Assumes the constants header sits beside it.
*/
`include "tsc_space_regs.svh"
package tsc_space_pkg;
    typedef struct packed {
        logic [7:0] opByte;
        logic [7:0] codeByte;
        logic [23:0] count;
        logic [7:0] ctlByte;
    } tsc_cmd_type;

    typedef struct packed {
        logic valid;
        logic filemark;
        logic endOfMediumFlag;
        logic physicalTapeEnd;
        logic logicalTapeStart;
        logic [3:0] senseKey;
        logic [23:0] info;
    } tsc_sense_type;

    typedef struct packed {
        logic item;
        logic filemark;
        logic endMark;
        logic blank;
        logic physEnd;
        logic physStart;
        logic mediaErr;
        logic hwErr;
        logic fixedBlk;
    } tsc_tape_ev_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FLUSH = 3'b001,
        ST_MOVE = 3'b010,
        ST_DONE = 3'b011
    } tsc_state_type;
endpackage

// *** hdl/tsc_space_cmd.sv ***
/*
 Tape space command sequencer: decodes the command block, flushes, steers motion, builds sense.
 Assumes the tape transport reports events as one-cycle pulses on clk_sys, and the flush engine
 answers with done or fail pulses.
*/
`timescale 1ns/1ps
module tsc_space_cmd
    import tsc_space_pkg::*;
#(
    parameter int unsigned FLUSH_LIMIT_CYC = `TSC_FLUSH_MAX_S * `TSC_CLK_HZ,
    parameter int unsigned ERASE_MBYTES = `TSC_ERASE_MBYTES
)(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire tsc_cmd_type cmd,
    output logic cmdReady,
    input wire logic lastWasWrite,
    input wire logic legacyFormat,
    input wire logic directorySupport,
    input wire logic disconnectEnable,
    input wire tsc_tape_ev_type tapeEv,
    input wire logic [31:0] erasedBytes,
    output logic moveForward,
    output logic moveBackward,
    output logic highSpeed,
    output logic fixedSpacing,
    output logic flushReq,
    input wire logic flushDone,
    input wire logic flushFail,
    output logic busReleased,
    output logic doneValid,
    output logic checkCondition,
    output tsc_sense_type sense
);
    // ==========================================================
    // parameter checks
    localparam longint unsigned ERASE_LIMIT = longint'(ERASE_MBYTES) * 1048576;
    initial begin
        if (FLUSH_LIMIT_CYC == 0 || ERASE_LIMIT > 64'hFFFFFFFF) begin
            $error("tsc_space_cmd: unusable parameter");
        end
    end

    // ==========================================================
    // decode
    tsc_state_type state_q;
    logic [2:0] spaceType;
    logic stopFirst;
    logic [23:0] count_q;
    logic [23:0] done_q;
    logic [2:0] type_q;
    logic back_q;
    logic stopFirst_q;
    logic firstMarkSeen_q;
    logic fmSeen_q;
    logic [31:0] flushCnt_q;
    logic [23:0] magnitude;
    logic [23:0] remain;
    logic [23:0] residue;
    logic [23:0] residueAfter;

    assign spaceType = cmd.codeByte[`TSC_CODE_MSB:`TSC_CODE_LSB]; // RQ1
    assign stopFirst = cmd.ctlByte[`TSC_STOPFIRST_BIT] | ~directorySupport; // RQ10 RQ11
    assign magnitude = cmd.count[23] ? 24'(-cmd.count) : cmd.count; // RQ2 RQ3
    assign remain = count_q - done_q;
    // backward residue carries the sign of the travel
    assign residue = back_q ? 24'(-remain) : remain; // RQ14 RQ18
    assign residueAfter = back_q ? 24'(-(remain - 24'h000001)) : remain - 24'h000001;
    assign cmdReady = (state_q == ST_IDLE);

    // ==========================================================
    // sequencer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            count_q <= 24'h000000;
            done_q <= 24'h000000;
            type_q <= 3'h0;
            back_q <= 1'b0;
            stopFirst_q <= 1'b0;
            firstMarkSeen_q <= 1'b0;
            fmSeen_q <= 1'b0;
            flushCnt_q <= 32'h00000000;
            doneValid <= 1'b0;
            checkCondition <= 1'b0;
            sense <= '0;
        end else begin
            doneValid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmdValid) begin
                        type_q <= spaceType;
                        count_q <= magnitude;
                        done_q <= 24'h000000;
                        back_q <= cmd.count[23] && spaceType != `TSC_TYPE_EOD;
                        stopFirst_q <= stopFirst;
                        firstMarkSeen_q <= 1'b0;
                        fmSeen_q <= 1'b0;
                        flushCnt_q <= 32'h00000000;
                        sense <= '0;
                        checkCondition <= 1'b0;
                        if (spaceType != `TSC_TYPE_BLOCKS && spaceType != `TSC_TYPE_FMARKS
                            && spaceType != `TSC_TYPE_EOD) begin
                            sense.senseKey <= `TSC_KEY_ILLEGAL; // RQ22
                            checkCondition <= 1'b1;
                            state_q <= ST_DONE;
                        end else if (spaceType == `TSC_TYPE_EOD && legacyFormat) begin
                            sense.senseKey <= `TSC_KEY_ILLEGAL; // RQ9
                            checkCondition <= 1'b1;
                            state_q <= ST_DONE;
                        end else if (spaceType != `TSC_TYPE_EOD && magnitude == 24'h000000) begin
                            state_q <= ST_DONE; // RQ4
                        end else if (lastWasWrite && !(cmd.count[23] && spaceType != `TSC_TYPE_EOD)) begin
                            sense.senseKey <= `TSC_KEY_ILLEGAL; // RQ8
                            checkCondition <= 1'b1;
                            state_q <= ST_DONE;
                        end else if (lastWasWrite) begin
                            state_q <= ST_FLUSH; // RQ6
                        end else begin
                            state_q <= ST_MOVE;
                        end
                    end
                end
                ST_FLUSH: begin
                    flushCnt_q <= flushCnt_q + 32'h00000001;
                    if (flushFail || flushCnt_q >= FLUSH_LIMIT_CYC) begin
                        // flush fault: space skipped, cause left for a sense request
                        sense.senseKey <= `TSC_KEY_HARDWARE; // RQ7
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (flushDone) begin
                        state_q <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    // priority: hard errors, tape ends, marks, then counted items
                    if (tapeEv.mediaErr || tapeEv.hwErr) begin
                        sense.senseKey <= tapeEv.hwErr ? `TSC_KEY_HARDWARE : `TSC_KEY_MEDIUM; // RQ19
                        sense.valid <= (type_q != `TSC_TYPE_EOD);
                        sense.info <= residue; // RQ14
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.physEnd) begin
                        sense.senseKey <= `TSC_KEY_MEDIUM; // RQ17
                        sense.endOfMediumFlag <= 1'b1;
                        sense.physicalTapeEnd <= 1'b1;
                        sense.valid <= (type_q != `TSC_TYPE_EOD);
                        sense.info <= residue;
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.physStart) begin
                        sense.senseKey <= `TSC_KEY_NOSENSE; // RQ18
                        sense.endOfMediumFlag <= 1'b1;
                        sense.logicalTapeStart <= 1'b1;
                        sense.valid <= 1'b1;
                        sense.info <= residue;
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.endMark && !stopFirst_q && !firstMarkSeen_q && !fmSeen_q) begin
                        firstMarkSeen_q <= 1'b1; // RQ12 RQ16
                    end else if (tapeEv.endMark && (firstMarkSeen_q || stopFirst_q || fmSeen_q)
                                 && type_q == `TSC_TYPE_EOD) begin
                        state_q <= ST_DONE; // RQ5
                    end else if ((tapeEv.endMark || tapeEv.blank) && type_q != `TSC_TYPE_EOD) begin
                        sense.senseKey <= `TSC_KEY_BLANK; // RQ15 RQ16
                        sense.valid <= 1'b1;
                        sense.info <= residue;
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.blank && firstMarkSeen_q
                                 && erasedBytes >= 32'(ERASE_LIMIT)) begin
                        sense.senseKey <= `TSC_KEY_BLANK; // RQ12
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.filemark && type_q == `TSC_TYPE_BLOCKS) begin
                        sense.senseKey <= `TSC_KEY_NOSENSE; // RQ13
                        sense.valid <= 1'b1;
                        sense.filemark <= 1'b1;
                        sense.info <= residue;
                        checkCondition <= 1'b1;
                        state_q <= ST_DONE;
                    end else if (tapeEv.filemark && type_q == `TSC_TYPE_FMARKS) begin
                        fmSeen_q <= 1'b1;
                        done_q <= done_q + 24'h000001;
                        if (residueAfter == 24'h000000) begin
                            state_q <= ST_DONE; // RQ2 RQ3
                        end
                    end else if (tapeEv.filemark) begin
                        fmSeen_q <= 1'b1;
                    end else if (tapeEv.item && type_q == `TSC_TYPE_BLOCKS) begin
                        done_q <= done_q + 24'h000001;
                        if (residueAfter == 24'h000000) begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    doneValid <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // motion outputs
    logic fixed_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fixed_q <= 1'b0;
        end else if (state_q == ST_MOVE && tapeEv.item) begin
            fixed_q <= tapeEv.fixedBlk; // RQ21
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            moveForward <= 1'b0;
            moveBackward <= 1'b0;
            highSpeed <= 1'b0;
            flushReq <= 1'b0;
            busReleased <= 1'b0;
        end else begin
            moveForward <= (state_q == ST_MOVE) && !back_q;
            moveBackward <= (state_q == ST_MOVE) && back_q;
            // erased stretch after the early end mark runs at speed
            highSpeed <= (state_q == ST_MOVE) && firstMarkSeen_q; // RQ12
            flushReq <= (state_q == ST_FLUSH);
            busReleased <= disconnectEnable && (state_q == ST_FLUSH || state_q == ST_MOVE); // RQ20
        end
    end

    assign fixedSpacing = fixed_q;
endmodule

// *** tb/tsc_flush_model.sv ***
/*
 Far-side flush engine model: answers a flush request after a fixed delay.
 Assumes flushReq is held high until done or fail is seen.
*/
`timescale 1ns/1ps
module tsc_flush_model #(
    parameter int DELAY = 10
)(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic flushReq,
    input wire logic failMode,
    output logic flushDone,
    output logic flushFail
);
    // ==========
    // answer once per request, never early
    logic [7:0] cnt_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            flushDone <= 1'b0;
            flushFail <= 1'b0;
        end else begin
            flushDone <= 1'b0;
            flushFail <= 1'b0;
            if (!flushReq) begin
                cnt_q <= 8'h00;
            end else if (cnt_q != 8'hFF) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == 8'(DELAY)) begin
                    flushDone <= !failMode;
                    flushFail <= failMode;
                end
            end
        end
    end
endmodule

// *** tb/tsc_space_properties.sv ***
/*
 Port checks of the space sequencer.
 Assumes it is bound onto tsc_space_cmd.
*/
`timescale 1ns/1ps
`include "tsc_space_regs.svh"
module tsc_space_properties
    import tsc_space_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire tsc_cmd_type cmd,
    input wire logic cmdReady,
    input wire logic lastWasWrite,
    input wire logic legacyFormat,
    input wire logic flushReq,
    input wire logic flushFail,
    input wire logic moveForward,
    input wire logic moveBackward,
    input wire logic doneValid,
    input wire logic checkCondition,
    input wire tsc_sense_type sense
);
    // ==========
    // helpers
    logic take;
    logic badCode;
    logic spaceType;
    assign take = cmdValid && cmdReady;
    assign badCode = !(cmd.codeByte[2:0] inside {`TSC_TYPE_BLOCKS, `TSC_TYPE_FMARKS, `TSC_TYPE_EOD});
    assign spaceType = cmd.codeByte[2:0] inside {`TSC_TYPE_BLOCKS, `TSC_TYPE_FMARKS};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ==========
    // checks
    a_zero_good: assert property (take && spaceType && cmd.count == 24'h0 && !lastWasWrite
        |-> ##2 doneValid && !checkCondition) else $error("zero count not good");
    a_bad_code: assert property (take && badCode
        |-> ##2 doneValid && checkCondition && sense.senseKey == `TSC_KEY_ILLEGAL) else $error("bad code kept");
    a_bad_still: assert property (take && badCode
        |=> (!moveForward && !moveBackward) [*3]) else $error("bad code moved");
    a_write_fwd: assert property (take && spaceType && !cmd.count[23] && cmd.count != 24'h0 && lastWasWrite
        |-> ##2 doneValid && checkCondition && sense.senseKey == `TSC_KEY_ILLEGAL) else $error("fwd after write");
    a_legacy_eod: assert property (take && cmd.codeByte[2:0] == `TSC_TYPE_EOD && legacyFormat
        |-> ##2 doneValid && checkCondition && sense.senseKey == `TSC_KEY_ILLEGAL) else $error("legacy eod");
    a_flush_first: assert property (take && spaceType && cmd.count[23] && lastWasWrite
        |-> ##[1:3] flushReq && !moveBackward) else $error("no flush");
    a_flush_fail: assert property (flushReq && flushFail
        |-> ##[1:3] doneValid && checkCondition && !moveBackward) else $error("flush fail");
    a_fm_sense: assert property (doneValid && sense.filemark
        |-> checkCondition && sense.valid && sense.senseKey == `TSC_KEY_NOSENSE) else $error("filemark sense");
    a_pe_sense: assert property (doneValid && sense.physicalTapeEnd
        |-> checkCondition && sense.endOfMediumFlag && sense.senseKey == `TSC_KEY_MEDIUM) else $error("end sense");
    a_start_sense: assert property (doneValid && sense.logicalTapeStart
        |-> checkCondition && sense.endOfMediumFlag && sense.info[23]) else $error("start sense");
endmodule

bind tsc_space_cmd tsc_space_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
    .cmd(cmd), .cmdReady(cmdReady), .lastWasWrite(lastWasWrite), .legacyFormat(legacyFormat),
    .flushReq(flushReq), .flushFail(flushFail), .moveForward(moveForward), .moveBackward(moveBackward),
    .doneValid(doneValid), .checkCondition(checkCondition), .sense(sense));

// *** tb/testbench.sv ***
/*
 Directed bench of the space sequencer: command sequences with expected status.
 Assumes the flush model sits on the flush handshake.
*/
`timescale 1ns/1ps
module testbench;
    import tsc_space_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, cmdValid = 1'b0, lastWasWrite = 1'b0;
    logic legacyFormat = 1'b0, directorySupport = 1'b0, failMode = 1'b0;
    logic disconnectEnable = 1'b1, stopBit = 1'b0;
    tsc_cmd_type cmd = '0;
    logic [8:0] tapeEv = 9'h000;
    logic cmdReady, moveForward, moveBackward, highSpeed, fixedSpacing, flushReq, flushDone, flushFail;
    logic busReleased, doneValid, checkCondition;
    tsc_sense_type sense;
    int n_fail = 0, num_checks = 0;
    logic [2:0] badCodes [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    always #2.5 clk_sys = ~clk_sys;
    tsc_space_cmd #(.FLUSH_LIMIT_CYC(50)) dut (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
        .cmd(cmd), .cmdReady(cmdReady), .lastWasWrite(lastWasWrite), .legacyFormat(legacyFormat),
        .directorySupport(directorySupport), .disconnectEnable(disconnectEnable), .tapeEv(tapeEv),
        .erasedBytes(32'h0), .moveForward(moveForward), .moveBackward(moveBackward),
        .highSpeed(highSpeed), .fixedSpacing(fixedSpacing), .flushReq(flushReq), .flushDone(flushDone),
        .flushFail(flushFail), .busReleased(busReleased), .doneValid(doneValid),
        .checkCondition(checkCondition), .sense(sense));
    tsc_flush_model #(.DELAY(10)) u_flush (.clk_sys(clk_sys), .nrst(nrst), .flushReq(flushReq),
        .failMode(failMode), .flushDone(flushDone), .flushFail(flushFail));
    // ==========
    // tasks
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [2:0] code, input logic [23:0] cnt, input logic wr);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        lastWasWrite <= wr;
        cmd <= '{8'h11, {5'h00, code}, cnt, {stopBit, 7'h00}};
        @(posedge clk_sys);
        cmdValid <= 1'b0;
    endtask
    task automatic pulse(input logic [8:0] e);
        @(posedge clk_sys);
        tapeEv <= e;
        @(posedge clk_sys);
        tapeEv <= 9'h000;
    endtask
    // bounded wait, a lost completion shows as a mismatch
    task automatic waitDone;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (doneValid === 1'b1) break;
        end
        chk(34'(doneValid), 34'h1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========
    // sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            send(3'(c), 24'h0, 1'b0);
            waitDone();
            chk(34'(checkCondition), 34'h0);
        end
        foreach (badCodes[k]) begin
            send(badCodes[k], 24'h1, 1'b0);
            waitDone();
            chk(34'({checkCondition, sense.senseKey}), 34'h15);
        end
        send(3'h1, 24'h1, 1'b1);
        waitDone();
        chk(34'({checkCondition, sense.senseKey}), 34'h15);
        @(posedge clk_sys) failMode <= 1'b1;
        send(3'h0, 24'hFFFFFF, 1'b1);
        waitDone();
        chk(34'({checkCondition, sense.senseKey, moveBackward}), 34'h28);
        @(posedge clk_sys) failMode <= 1'b0;
        send(3'h0, 24'hFFFFFF, 1'b1);
        repeat (20) @(posedge clk_sys);
        #1 chk(34'(moveBackward), 34'h1);
        pulse(9'h100);
        waitDone();
        chk(34'(checkCondition), 34'h0);
        send(3'h0, 24'h2, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1 chk(34'({moveForward, busReleased}), 34'h3);
        pulse(9'h100);
        pulse(9'h101);
        waitDone();
        chk(34'({checkCondition, fixedSpacing}), 34'h1);
        send(3'h0, 24'h3, 1'b0);
        pulse(9'h100);
        pulse(9'h080);
        waitDone();
        chk({checkCondition, sense}, {6'h38, 4'h0, 24'h000002});
        chk(34'(fixedSpacing), 34'h0);
        send(3'h0, 24'hFFFFFE, 1'b0);
        pulse(9'h008);
        waitDone();
        chk({checkCondition, sense}, {6'h35, 4'h0, 24'hFFFFFE});
        @(posedge clk_sys) disconnectEnable <= 1'b0;
        send(3'h0, 24'h4, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1 chk(34'({moveForward, busReleased}), 34'h2);
        pulse(9'h100);
        pulse(9'h010);
        waitDone();
        chk({checkCondition, sense}, {6'h36, 4'h3, 24'h000003});
        send(3'h1, 24'h2, 1'b0);
        pulse(9'h080);
        pulse(9'h020);
        waitDone();
        chk({checkCondition, sense}, {6'h30, 4'h8, 24'h000001});
        send(3'h0, 24'h2, 1'b0);
        pulse(9'h100);
        pulse(9'h004);
        waitDone();
        chk(34'({checkCondition, sense.senseKey, sense.info}), 34'({1'b1, 4'h3, 24'h000001}));
        @(posedge clk_sys) legacyFormat <= 1'b1;
        send(3'h3, 24'h0, 1'b0);
        waitDone();
        chk(34'({checkCondition, sense.senseKey}), 34'h15);
        @(posedge clk_sys) legacyFormat <= 1'b0;
        directorySupport <= 1'b1;
        send(3'h0, 24'h5, 1'b0);
        pulse(9'h040);
        @(posedge clk_sys);
        #1 chk(34'(highSpeed), 34'h1);
        pulse(9'h040);
        waitDone();
        chk(34'({checkCondition, sense.senseKey}), 34'h18);
        send(3'h3, 24'h5, 1'b0);
        pulse(9'h040);
        pulse(9'h040);
        waitDone();
        chk(34'(checkCondition), 34'h0);
        @(posedge clk_sys) stopBit <= 1'b1;
        send(3'h0, 24'h5, 1'b0);
        pulse(9'h040);
        waitDone();
        chk(34'({checkCondition, sense.senseKey}), 34'h18);
        end_sim();
    end
    // run needs under 150 cycles; this is far beyond
    initial begin
        #100us;
        n_fail++;
        end_sim();
    end
endmodule
